// *** src/conv_two_ctrl.sv ***
// Start control, busy status and flags of the secondary converter.
`timescale 1ns/1ps
`default_nettype none
module conv_two_ctrl #(
    parameter int DIV        = conv_two_pkg::CONV_CLK_DIV,
    parameter int CONV_LEN   = conv_two_pkg::CONV_PERIODS
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_RD,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       PRIMARY_BUSY_WRITE,
    input  wire logic       TIMER3_OVERFLOW,
    input  wire logic       TIMER2_OVERFLOW,
    input  wire logic       EXT_CONVERT_START,
    input  wire logic       WINDOW_MATCH,
    output logic            CONVERTER_POWERED,
    output logic            TRACKING,
    output logic            CONVERTING,
    output logic            CONVERT_DONE
);
    import conv_two_pkg::*;

    // Whole module state in one packed struct.
    typedef struct packed {
        logic       enable;     // Converter enable bit.
        logic       track_mode; // Low-power track mode bit.
        logic       done;       // Conversion complete flag.
        logic [2:0] mode;       // Start-mode field.
        logic       window;     // Window compare flag.
        seq_state_t seq;        // Sequencer state.
        logic [7:0] periods;    // Converter periods left in current phase.
        logic       ext_prev;   // Previous level of the start pin.
        logic [7:0] rdata;      // Read data register.
        logic       powered;    // Power output.
        logic       tracking;   // Tracking output.
        logic       converting; // Busy output.
        logic       cdone;      // Completion pulse output.
    } ctrl_state_t;

    // The state and its next value; only s_reg is held in flip-flops.
    ctrl_state_t s_reg;  // Registered state.
    ctrl_state_t s_next; // Next state.
    logic        tick;   // One pulse per converter clock period.

    // Converter clock runs only while a phase is under way. Holding the
    // divider cleared while idle makes every phase that starts from idle
    // begin on a fresh converter clock, so the timed track is never cut short.
    conv_two_tick #(
        .DIV (DIV)
    ) u_tick (
        .clk  (CLK),
        .rst  (RST),
        .run  (s_reg.enable && s_reg.seq != ST_IDLE),
        .tick (tick)
    );

    // Pack the control register for reads. The busy bit is not stored;
    // it is read back from the sequencer so that it can never disagree
    // with the converting output.
    function automatic logic [7:0] pack_ctrl(input ctrl_state_t s);
        pack_ctrl = {s.enable, s.track_mode, s.done,
                     s.seq == ST_CONVERT, s.mode, s.window};
    endfunction

    // Next-state logic for register writes, start selection and sequencing.
    always_comb begin
        logic ctrl_wr;    // Write to the control register this cycle.
        logic busy_write; // Software wrote one to the busy bit.
        logic ext_rise;   // Rising edge on the start pin.
        logic start_evt;  // Selected start event.
        logic conv_end;   // Conversion finishes this cycle.
        ctrl_wr    = 1'b0;
        busy_write = 1'b0;
        ext_rise   = 1'b0;
        start_evt  = 1'b0;
        conv_end   = 1'b0;
        s_next     = s_reg;

        // Decode this cycle's events. A busy write is judged against the
        // mode held before the write, so a write that changes the mode
        // and sets the busy bit starts with the old code.
        ctrl_wr    = SFR_WR && SFR_ADDR == CTRL_ADDR;
        busy_write = ctrl_wr && SFR_WDATA[BUSY_POS];
        ext_rise   = EXT_CONVERT_START && !s_reg.ext_prev;
        // Remember the pin level for next cycle's edge test.
        s_next.ext_prev = EXT_CONVERT_START;

        // Register write; flag bits accept software writes.
        // The busy bit is not stored: a one is only a start event and a
        // zero does nothing at all.
        if (ctrl_wr) begin
            s_next.enable     = SFR_WDATA[ENABLE_POS];
            s_next.track_mode = SFR_WDATA[TRACK_MODE_POS];
            s_next.done       = SFR_WDATA[DONE_POS];
            s_next.mode       = SFR_WDATA[MODE_HI_POS:MODE_LO_POS];
            s_next.window     = SFR_WDATA[WINDOW_POS];
        end

        // Pick the start event for the current mode code.
        // Codes with the top bit set follow the primary converter's starts.
        if (s_reg.mode[2]) begin
            start_evt = PRIMARY_BUSY_WRITE;
        end else begin
            case (s_reg.mode)
                MODE_SOFT:    start_evt = busy_write;
                MODE_TIMER3:  start_evt = TIMER3_OVERFLOW;
                MODE_EXT_PIN: start_evt = ext_rise;
                MODE_TIMER2:  start_evt = TIMER2_OVERFLOW;
                default:      start_evt = 1'b0;
            endcase
        end

        // Sequencer.
        case (s_reg.seq)
            ST_IDLE: begin
                // Low-power codes other than the pin code track first.
                if (s_reg.enable && start_evt) begin
                    if (s_reg.track_mode &&
                        s_reg.mode != MODE_EXT_PIN) begin
                        s_next.seq     = ST_TRACK;
                        s_next.periods = 8'(TRACK_PERIODS);
                    end else begin
                        // The pin code already tracked while it was low.
                        s_next.seq     = ST_CONVERT;
                        s_next.periods = 8'(CONV_LEN);
                    end
                end
            end
            ST_TRACK: begin
                // Conversion follows the timed track immediately.
                if (tick && s_reg.periods == 8'h01) begin
                    s_next.seq     = ST_CONVERT;
                    s_next.periods = 8'(CONV_LEN);
                end else if (tick) begin
                    s_next.periods = s_reg.periods - 8'h01;
                end
            end
            ST_CONVERT: begin
                // The last converter period ends the conversion.
                if (tick && s_reg.periods == 8'h01) begin
                    s_next.seq = ST_IDLE;
                    conv_end   = 1'b1;
                end else if (tick) begin
                    s_next.periods = s_reg.periods - 8'h01;
                end
            end
            default: begin
                // Unused state encoding; recover to idle.
                s_next.seq = ST_IDLE;
            end
        endcase

        // Disabling aborts any activity.
        // A conversion cut short this way does not set the done flag.
        if (!s_reg.enable) begin
            s_next.seq = ST_IDLE;
        end

        // Hardware sets win over software clears.
        // A completion and a clear in the same cycle leave the flag set.
        if (conv_end) begin
            s_next.done = 1'b1;
        end
        if (conv_end && WINDOW_MATCH) begin
            s_next.window = 1'b1;
        end

        // Outputs from next state so each output is a flip-flop.
        s_next.powered    = s_next.enable;
        s_next.converting = s_next.seq == ST_CONVERT;
        if (!s_next.enable) begin
            // Shutdown: nothing is tracked.
            s_next.tracking = 1'b0;
        end else if (!s_next.track_mode) begin
            // Normal mode tracks whenever it is not converting.
            s_next.tracking = s_next.seq != ST_CONVERT;
        end else if (s_next.mode == MODE_EXT_PIN) begin
            // Pin code: track while idle and the pin is low.
            s_next.tracking = s_next.seq == ST_IDLE &&
                              !EXT_CONVERT_START;
        end else begin
            // Timed codes: track only during the timed phase.
            s_next.tracking = s_next.seq == ST_TRACK;
        end
        // Done pulse marks the cycle in which the busy bit falls.
        s_next.cdone = conv_end;
        // Reads return the state after this edge, so a read in the cycle
        // a conversion ends already shows busy clear. Others read zero.
        s_next.rdata = (SFR_RD && SFR_ADDR == CTRL_ADDR) ?
                       pack_ctrl(s_next) : 8'h00;
    end

    // Register the whole state.
    always_ff @(posedge CLK) begin
        if (RST) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Every output comes straight from a field of the registered state.
    assign SFR_RDATA         = s_reg.rdata;
    assign CONVERTER_POWERED = s_reg.powered;
    assign TRACKING          = s_reg.tracking;
    assign CONVERTING        = s_reg.converting;
    assign CONVERT_DONE      = s_reg.cdone;
endmodule
`default_nettype wire

// *** src/conv_two_pkg.sv ***
// Package with register layout, reset values and timing for converter two.
package conv_two_pkg;

    // Register address of the control register in the special register space.
    localparam logic [7:0] CTRL_ADDR      = 8'hE8;
    // Value of the control register after reset.
    localparam logic [7:0] CTRL_RESET     = 8'h00;

    // Bit positions within the control register.
    localparam int ENABLE_POS     = 7;
    localparam int TRACK_MODE_POS = 6;
    localparam int DONE_POS       = 5;
    localparam int BUSY_POS       = 4;
    localparam int MODE_HI_POS    = 3;
    localparam int MODE_LO_POS    = 1;
    localparam int WINDOW_POS     = 0;

    // Start-mode codes.
    localparam logic [2:0] MODE_SOFT      = 3'h0;
    localparam logic [2:0] MODE_TIMER3    = 3'h1;
    localparam logic [2:0] MODE_EXT_PIN   = 3'h2;
    localparam logic [2:0] MODE_TIMER2    = 3'h3;

    // Timed tracking length in converter clock periods.
    localparam int TRACK_PERIODS  = 3;
    // Converter clock periods taken by one conversion.
    localparam int CONV_PERIODS   = 16;
    // System clocks per converter clock period (default divider).
    localparam int CONV_CLK_DIV   = 4;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TRACK,
        ST_CONVERT
    } seq_state_t;

endpackage

// *** src/conv_two_tick.sv ***
// Divider that makes the converter clock tick from the system clock.
`timescale 1ns/1ps
`default_nettype none
module conv_two_tick #(
    parameter int DIV = conv_two_pkg::CONV_CLK_DIV
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);
    import conv_two_pkg::*;

    // Divider state kept as one packed struct.
    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } tick_state_t;

    tick_state_t state_reg;  // Registered divider state.
    tick_state_t state_next; // Next divider state.

    // Count system clocks and pulse once per converter period while running.
    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (!run) begin
            state_next.count = 8'h00;
        end else if (state_reg.count == 8'(DIV - 1)) begin
            state_next.count = 8'h00;
            state_next.tick  = 1'b1;
        end else begin
            state_next.count = state_reg.count + 8'h01;
        end
    end

    // Register the divider state.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule
`default_nettype wire

// *** dv/conv_two_sva.sv ***
// Checker for converter two start control.
`timescale 1ns/1ps
`default_nettype none
module conv_two_sva #(
    parameter int DIV      = 4,
    parameter int CONV_LEN = 16
) (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic       SFR_WR,
    input wire logic       SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic       CONVERTER_POWERED,
    input wire logic       TRACKING,
    input wire logic       CONVERTING,
    input wire logic       CONVERT_DONE
);
    int busy_len;  // Cycles the running conversion has lasted.
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Count busy cycles; cleared between conversions.
    always_ff @(posedge CLK) begin
        busy_len <= (RST || !CONVERTING) ? 0 : busy_len + 1;
    end
    a_off_no_track: assert property (!CONVERTER_POWERED |-> !TRACKING)
        else $error("tracking while off");
    a_power_by_write: assert property ($changed(CONVERTER_POWERED)
        |-> $past(SFR_WR) || $past(SFR_WR, 2)) else $error("power moved");
    a_busy_no_track: assert property (CONVERTING |-> !TRACKING)
        else $error("tracking while busy");
    a_done_on_fall: assert property ($fell(CONVERTING) |-> CONVERT_DONE)
        else $error("no done");
    a_done_has_cause: assert property (CONVERT_DONE |-> $fell(CONVERTING))
        else $error("stray done");
    a_conv_length: assert property ($fell(CONVERTING) |->
        busy_len >= CONV_LEN * DIV - 4 && busy_len <= CONV_LEN * DIV + 4)
        else $error("bad length");
    a_read_other: assert property (SFR_RD && SFR_ADDR != 8'hE8
        |=> SFR_RDATA == 8'h00) else $error("unmapped data");
    a_read_status: assert property (SFR_RD && SFR_ADDR == 8'hE8
        |=> {SFR_RDATA[7], SFR_RDATA[4]}
            == {CONVERTER_POWERED, CONVERTING})
        else $error("status data");
endmodule
bind conv_two_ctrl conv_two_sva #(.DIV(DIV), .CONV_LEN(CONV_LEN)) chk (
    .CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
    .CONVERTER_POWERED(CONVERTER_POWERED), .TRACKING(TRACKING),
    .CONVERTING(CONVERTING), .CONVERT_DONE(CONVERT_DONE));
`default_nettype wire

// *** dv/core_model.sv ***
// Processor core model issuing control register accesses.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       clk,
    output logic      [7:0] addr,
    output logic            wr,
    output logic      [7:0] wdata,
    output logic            rd,
    input  wire logic [7:0] rdata
);
    // Idle bus at time zero.
    initial begin
        {addr, wr, wdata, rd} = 18'h0;
    end
    // One write cycle; flags are cleared by writing zero to them.
    task automatic wr_reg(input logic [7:0] d);
        @(negedge clk);
        {addr, wdata, wr} = {8'hE8, d, 1'b1};
        @(negedge clk);
        wr = 1'b0;
        wdata = ~d;
    endtask
    // One read cycle; data is registered, so taken one cycle on.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// *** dv/test_adc_conversion_start_control.sv ***
// Self-checking bench for converter two start control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module test_adc_conversion_start_control;
    import conv_two_pkg::*;
    localparam int TT = TRACK_PERIODS * CONV_CLK_DIV;  // Timed track cycles.
    logic       clk;
    logic       rst;
    logic       t3, t2, ext, pbw, win;
    logic [7:0] addr, wdata, rdata, v;
    logic       wr, rd, pwr, trk, busy, done;
    int         n_mismatch = 0;
    int         tests_run = 0;
    int         n;
    always #2 clk = ~clk;
    core_model core (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata),
        .rd(rd), .rdata(rdata));
    conv_two_ctrl uut (.CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WR(wr),
        .SFR_WDATA(wdata), .SFR_RD(rd), .SFR_RDATA(rdata),
        .PRIMARY_BUSY_WRITE(pbw), .TIMER3_OVERFLOW(t3),
        .TIMER2_OVERFLOW(t2), .EXT_CONVERT_START(ext), .WINDOW_MATCH(win),
        .CONVERTER_POWERED(pwr), .TRACKING(trk), .CONVERTING(busy),
        .CONVERT_DONE(done));
    // Print the verdict and end the run.
    task automatic report_and_stop;
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Wait, bounded, until busy equals b.
    task automatic wait_busy(input logic b);
        for (n = 0; busy !== b && n < 300; n++) @(negedge clk);
        if (busy !== b) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask
    // Raise the start event of code m; the pin stays high.
    task automatic fire(input logic [2:0] m);
        @(negedge clk);
        {t3, t2, ext, pbw} = {m == 3'h1, m == 3'h3, m == 3'h2, m[2]};
        @(negedge clk);
        {t3, t2, pbw} = 3'h0;
    endtask
    // Reset value, unmapped read, idle tracking, software start.
    task automatic s_soft;
        core.rd_reg(CTRL_ADDR, v);
        `CHK(v, CTRL_RESET)
        core.rd_reg(8'h55, v);
        `CHK(v, 8'h00)
        core.wr_reg(8'h80);
        core.wr_reg(8'h80);
        repeat (3) @(negedge clk);
        `CHK({pwr, trk, busy}, 3'h6)
        core.wr_reg(8'h90);
        wait_busy(1'b1);
        `CHK(trk, 1'b0)
        core.rd_reg(CTRL_ADDR, v);
        `CHK(v[BUSY_POS], 1'b1)
        wait_busy(1'b0);
        `CHK(done, 1'b1)
        `CHK(trk, 1'b1)
        core.rd_reg(CTRL_ADDR, v);
        `CHK(v, 8'hA0)
        core.wr_reg(8'h80);
        core.rd_reg(CTRL_ADDR, v);
        `CHK(v, 8'h80)
    endtask
    // Codes 1 to 4 in normal mode, with busy writes ignored there.
    task automatic s_modes;
        win = 1'b1;
        for (int m = 1; m < 5; m++) begin
            core.wr_reg(8'h80 | 8'(m << 1));
            core.wr_reg(8'h90 | 8'(m << 1));
            repeat (3) @(negedge clk);
            `CHK(busy, 1'b0)
            fire(3'(m));
            wait_busy(1'b1);
            `CHK(trk, 1'b0)
            wait_busy(1'b0);
            ext = 1'b0;
        end
        win = 1'b0;
        core.rd_reg(CTRL_ADDR, v);
        `CHK(v[WINDOW_POS], 1'b1)
    endtask
    // Timed tracking on each timer, then tracking gated by the pin.
    task automatic s_lowpow;
        for (int i = 0; i < 2; i++) begin
            core.wr_reg(i ? 8'hC6 : 8'hC2);
            repeat (3) @(negedge clk);
            `CHK(trk, 1'b0)
            fire(i ? MODE_TIMER2 : MODE_TIMER3);
            n = 0;
            for (int k = 0; busy !== 1'b1 && k < 100; k++) begin
                @(negedge clk);
                n += (trk === 1'b1);
            end
            `CHK(n >= TT - 1 && n <= TT + 1, 1'b1)
            wait_busy(1'b0);
        end
        core.wr_reg(8'hC4);
        repeat (3) @(negedge clk);
        `CHK(trk, 1'b1)
        ext = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        `CHK(trk, 1'b0)
        ext = 1'b0;
    endtask
    // Clearing the enable returns to shutdown.
    task automatic s_off;
        core.wr_reg(8'h00);
        repeat (3) @(negedge clk);
        `CHK({pwr, trk, busy}, 3'h0)
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        t3 = 1'b0;
        t2 = 1'b0;
        ext = 1'b0;
        pbw = 1'b0;
        win = 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        s_soft;
        s_modes;
        s_lowpow;
        s_off;
        report_and_stop;
    end
endmodule
`default_nettype wire
